// File: verilog/psmc_top.sv
// Operating-mode controller of a barometric pressure and temperature sensor.
module psmc_top #(
	parameter int TICK_CYCLES = psmc_pkg::TICK_CYCLES,
	parameter int BOOT_TICKS  = psmc_pkg::BOOT_TICKS
) (
	input  wire  logic                   clk_sys,
	input  wire  logic                   sys_rst,
	input  wire  logic [7:0]             reg_addr,
	input  wire  logic                   reg_wr,
	input  wire  logic [7:0]             reg_wdata,
	input  wire  logic                   reg_rd,
	output logic       [7:0]             reg_rdata,
	output logic                         reg_rvalid,
	input  wire  psmc_pkg::psmc_sample_s adc_sample,
	output logic                         afe_enable,
	output logic                         sample_done,
	output psmc_pkg::psmc_mode_e         mode
);
	// The divider is 16 bits and the boot counter shares the 20-bit microsecond width.
	if (TICK_CYCLES < 1 || TICK_CYCLES > 65535 || BOOT_TICKS < 1 || BOOT_TICKS > 1048575) begin : g_bad_timing
		$error("psmc_top: timing parameters out of range");
	end

	// ****************************************************************
	// Microsecond tick divider
	// ****************************************************************
	logic [15:0] div_q;
	logic        tick;
	assign tick = (div_q == 16'(TICK_CYCLES - 1));
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			div_q <= 16'h0000;
		end else begin
			div_q <= tick ? 16'h0000 : div_q + 16'h0001;
		end
	end

	// ****************************************************************
	// Register decode
	// ****************************************************************
	logic [3:0]             rate_q;
	logic [2:0]             avg_q;
	logic                   single_q;
	psmc_pkg::psmc_sample_s out_q;
	psmc_pkg::psmc_mode_e   mode_q;
	wire logic wr_ctrl1;
	wire logic wr_ctrl2;
	wire logic wr_single;
	wire logic [7:0] rd_mux;
	assign wr_ctrl1  = reg_wr && (reg_addr == psmc_pkg::ADDR_RATE_AVG_CTRL);
	assign wr_ctrl2  = reg_wr && (reg_addr == psmc_pkg::ADDR_SINGLE_CTRL);
	assign wr_single = wr_ctrl2 && reg_wdata[psmc_pkg::SINGLE_BIT] && (mode_q != psmc_pkg::PSMC_CONT);
	assign rd_mux =
		(reg_addr == psmc_pkg::ADDR_RATE_AVG_CTRL) ? {1'b0, rate_q, avg_q} :
		(reg_addr == psmc_pkg::ADDR_SINGLE_CTRL)   ? {7'h00, single_q} :
		(reg_addr == psmc_pkg::ADDR_PRESS_XL)      ? out_q.press[7:0] :
		(reg_addr == psmc_pkg::ADDR_PRESS_L)       ? out_q.press[15:8] :
		(reg_addr == psmc_pkg::ADDR_PRESS_H)       ? out_q.press[23:16] :
		(reg_addr == psmc_pkg::ADDR_TEMP_L)        ? out_q.temp[7:0] :
		(reg_addr == psmc_pkg::ADDR_TEMP_H)        ? out_q.temp[15:8] :
		8'h00;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rdata  <= reg_rd ? rd_mux : reg_rdata;
			reg_rvalid <= reg_rd;
		end
	end

	// Configuration is only ever changed by the host, never by a mode change.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rate_q <= psmc_pkg::RATE_RESET;
			avg_q  <= psmc_pkg::AVG_RESET;
		end else if (wr_ctrl1) begin
			rate_q <= reg_wdata[psmc_pkg::RATE_LSB +: 4];
			avg_q  <= reg_wdata[psmc_pkg::AVG_LSB +: 3];
		end
	end

	// ****************************************************************
	// Mode sequencer
	// ****************************************************************
	psmc_pkg::psmc_mode_e mode_d;
	psmc_pkg::psmc_us_t   boot_q;
	psmc_pkg::psmc_us_t   conv_q;
	psmc_pkg::psmc_us_t   per_q;
	logic                 conv_run_q;
	wire logic rate_on;
	wire logic boot_end;
	wire logic conv_end;
	wire logic per_end;
	wire logic start_cont;
	wire logic single_end;
	wire logic conv_start;
	wire logic conv_stop;
	assign rate_on    = (rate_q != psmc_pkg::RATE_POWER_DOWN);
	assign boot_end   = tick && (boot_q == psmc_pkg::psmc_us_t'(BOOT_TICKS - 1));
	// Greater-or-equal lets a conversion end even if the averaging code shrinks while it runs.
	assign conv_end   = conv_run_q && tick
		&& (conv_q >= psmc_pkg::conv_us(avg_q) - psmc_pkg::psmc_us_t'(1));
	assign per_end    = tick && (per_q == psmc_pkg::period_us(rate_q) - psmc_pkg::psmc_us_t'(1));
	assign start_cont = (mode_q == psmc_pkg::PSMC_PDOWN) && rate_on;
	assign single_end = (mode_q == psmc_pkg::PSMC_SINGLE) && conv_end;

	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			psmc_pkg::PSMC_BOOT: begin
				if (boot_end) begin
					mode_d = psmc_pkg::PSMC_PDOWN;
				end
			end
			psmc_pkg::PSMC_PDOWN: begin
				if (rate_on) begin
					mode_d = psmc_pkg::PSMC_CONT;
				end else if (single_q) begin
					mode_d = psmc_pkg::PSMC_SINGLE;
				end
			end
			psmc_pkg::PSMC_SINGLE: begin
				if (conv_end) begin
					mode_d = psmc_pkg::PSMC_PDOWN;
				end
			end
			default: begin
				if (!rate_on) begin
					mode_d = psmc_pkg::PSMC_PDOWN;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			mode_q <= psmc_pkg::PSMC_BOOT;
			boot_q <= '0;
		end else begin
			mode_q <= mode_d;
			if (mode_q == psmc_pkg::PSMC_BOOT && tick) begin
				boot_q <= boot_q + psmc_pkg::psmc_us_t'(1);
			end
		end
	end

	// ****************************************************************
	// Period and conversion counters
	// ****************************************************************
	assign conv_start = start_cont
		|| (mode_q == psmc_pkg::PSMC_CONT && (per_end || wr_ctrl1) && rate_on)
		|| (mode_q == psmc_pkg::PSMC_PDOWN && !rate_on && single_q);
	assign conv_stop  = conv_end || (mode_d == psmc_pkg::PSMC_PDOWN);

	// A new rate or averaging code restarts the period, so a stale count never overruns.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			per_q <= '0;
		end else if (mode_q != psmc_pkg::PSMC_CONT || wr_ctrl1 || per_end) begin
			per_q <= '0;
		end else if (tick) begin
			per_q <= per_q + psmc_pkg::psmc_us_t'(1);
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			conv_run_q <= 1'b0;
			conv_q     <= '0;
		end else if (conv_start) begin
			conv_run_q <= 1'b1;
			conv_q     <= '0;
		end else if (conv_stop) begin
			conv_run_q <= 1'b0;
			conv_q     <= '0;
		end else if (conv_run_q && tick) begin
			conv_q <= conv_q + psmc_pkg::psmc_us_t'(1);
		end
	end

	// ****************************************************************
	// Request flag and output data
	// ****************************************************************
	// A request written in the completing cycle wins over the self-clear.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			single_q <= 1'b0;
		end else if (wr_single) begin
			single_q <= 1'b1;
		end else if (single_end) begin
			single_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			out_q       <= '0;
			sample_done <= 1'b0;
			afe_enable  <= 1'b0;
			mode        <= psmc_pkg::PSMC_BOOT;
		end else begin
			out_q       <= conv_end ? adc_sample : out_q;
			sample_done <= conv_end;
			afe_enable  <= (mode_d != psmc_pkg::PSMC_PDOWN) && (mode_d != psmc_pkg::PSMC_BOOT);
			mode        <= mode_d;
		end
	end
endmodule : psmc_top

// File: inc/psmc_pkg.sv
// Package of constants and types for the pressure sensor mode controller.
package psmc_pkg;
	// ****************************************************************
	// Register map and fields
	// ****************************************************************
	localparam logic [7:0] ADDR_RATE_AVG_CTRL = 8'h10;
	localparam logic [7:0] ADDR_SINGLE_CTRL   = 8'h11;
	localparam logic [7:0] ADDR_PRESS_XL      = 8'h28;
	localparam logic [7:0] ADDR_PRESS_L       = 8'h29;
	localparam logic [7:0] ADDR_PRESS_H       = 8'h2a;
	localparam logic [7:0] ADDR_TEMP_L        = 8'h2b;
	localparam logic [7:0] ADDR_TEMP_H        = 8'h2c;
	localparam int         RATE_LSB           = 3;
	localparam int         AVG_LSB            = 0;
	localparam int         SINGLE_BIT         = 0;
	localparam logic [3:0] RATE_RESET         = 4'h0;
	localparam logic [3:0] RATE_POWER_DOWN    = 4'h0;
	localparam logic [2:0] AVG_RESET          = 3'h0;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_MHZ      = 100;
	localparam int TICK_US      = 1;
	localparam int TICK_CYCLES  = TICK_US * CLK_MHZ;
	localparam int BOOT_TIME_MS = 10;
	localparam int BOOT_TICKS   = BOOT_TIME_MS * 1000 / TICK_US;
	localparam int US_W         = 20;

	typedef logic [US_W-1:0] psmc_us_t;

	typedef enum logic [1:0] {
		PSMC_BOOT,
		PSMC_PDOWN,
		PSMC_SINGLE,
		PSMC_CONT
	} psmc_mode_e;

	typedef struct packed {
		logic [23:0] press;
		logic [15:0] temp;
	} psmc_sample_s;

	// Typical conversion time in microseconds per averaging code.
	function automatic psmc_us_t conv_us(input logic [2:0] avg);
		case (avg)
			3'h0:    conv_us = psmc_us_t'(1200);
			3'h1:    conv_us = psmc_us_t'(1500);
			3'h2:    conv_us = psmc_us_t'(2400);
			3'h3:    conv_us = psmc_us_t'(3400);
			3'h4:    conv_us = psmc_us_t'(5400);
			3'h5:    conv_us = psmc_us_t'(9400);
			default: conv_us = psmc_us_t'(33400);
		endcase
	endfunction : conv_us

	// Output period in microseconds per rate code, rounded down.
	function automatic psmc_us_t period_us(input logic [3:0] rate);
		case (rate)
			4'h1:    period_us = psmc_us_t'(1000000);
			4'h2:    period_us = psmc_us_t'(250000);
			4'h3:    period_us = psmc_us_t'(100000);
			4'h4:    period_us = psmc_us_t'(40000);
			4'h5:    period_us = psmc_us_t'(20000);
			4'h6:    period_us = psmc_us_t'(13333);
			4'h7:    period_us = psmc_us_t'(10000);
			default: period_us = psmc_us_t'(5000);
		endcase
	endfunction : period_us
endpackage : psmc_pkg

// File: test/psmc_conv_model.sv
// Converter stand-in that feeds sample words to the mode controller.
module psmc_conv_model (
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	input  wire logic              afe_enable,
	input  wire logic              sample_done,
	output psmc_pkg::psmc_sample_s adc_sample
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] n_q;
	logic        flip_q;
	// With the front end off the word toggles every cycle, so a stray load shows up.
	assign adc_sample = afe_enable ? {24'h5a0000 + 24'(n_q), 16'h3c00 + n_q} : {40{flip_q}};
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			n_q <= 16'h0;
			flip_q <= 1'b0;
		end else begin
			n_q <= n_q + 16'(sample_done);
			flip_q <= ~flip_q;
		end
	end
endmodule : psmc_conv_model

// File: test/psmc_chk_assertions.sv
// Assertions on the mode controller ports.
module psmc_chk (
	input wire logic                   clk_sys,
	input wire logic                   sys_rst,
	input wire logic [7:0]             reg_addr,
	input wire logic                   reg_wr,
	input wire logic [7:0]             reg_wdata,
	input wire logic                   reg_rd,
	input wire logic [7:0]             reg_rdata,
	input wire logic                   reg_rvalid,
	input wire psmc_pkg::psmc_sample_s adc_sample,
	input wire logic                   afe_enable,
	input wire logic                   sample_done,
	input wire psmc_pkg::psmc_mode_e   mode
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	wire logic busy = mode == psmc_pkg::PSMC_SINGLE || mode == psmc_pkg::PSMC_CONT;
	wire logic rate_wr = reg_wr && reg_addr == psmc_pkg::ADDR_RATE_AVG_CTRL;
	rd_answer_a: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered");
	afe_mode_a: assert property (afe_enable == busy)
		else $error("front end out of step with mode");
	boot_idle_a: assert property (mode == psmc_pkg::PSMC_BOOT |-> !afe_enable && !sample_done)
		else $error("activity during boot");
	single_end_a: assert property (sample_done && $past(mode) == psmc_pkg::PSMC_SINGLE |-> mode == psmc_pkg::PSMC_PDOWN)
		else $error("single capture did not return to power-down");
	pdown_quiet_a: assert property (mode == psmc_pkg::PSMC_PDOWN && $past(mode) == psmc_pkg::PSMC_PDOWN |-> !sample_done)
		else $error("update in power-down");
	cont_start_a: assert property (mode == psmc_pkg::PSMC_PDOWN && rate_wr && reg_wdata[6:3] != 4'h0 |=> ##[0:2] mode == psmc_pkg::PSMC_CONT)
		else $error("continuous mode not entered");
	cont_stop_a: assert property (mode == psmc_pkg::PSMC_CONT && rate_wr && reg_wdata[6:3] == 4'h0 |=> ##[0:2] mode == psmc_pkg::PSMC_PDOWN)
		else $error("power-down not entered");
	done_pulse_a: assert property (sample_done |=> !sample_done)
		else $error("update pulse too long");
	cover property (mode == psmc_pkg::PSMC_SINGLE ##1 mode == psmc_pkg::PSMC_PDOWN);
	cover property (sample_done && mode == psmc_pkg::PSMC_CONT);
	cover property (reg_rvalid);
	cover property (mode == psmc_pkg::PSMC_CONT && reg_wr && reg_addr == psmc_pkg::ADDR_SINGLE_CTRL && reg_wdata[0]);
endmodule : psmc_chk
bind psmc_top psmc_chk u_psmc_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.adc_sample(adc_sample), .afe_enable(afe_enable), .sample_done(sample_done), .mode(mode));

// File: test/tb.sv
// Testbench of the pressure sensor mode controller.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic                   clk_sys = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, reg_rvalid, afe_enable, sample_done;
	logic [7:0]             reg_addr = 0, reg_wdata = 0, reg_rdata, v;
	logic [39:0]            e;
	psmc_pkg::psmc_sample_s adc_sample;
	psmc_pkg::psmc_mode_e   mode;
	int                     failures = 0, n_tests = 0, cyc = 0, ncap = 0, n;
	int                     cv[7] = '{1200, 1500, 2400, 3400, 5400, 9400, 33400};
	logic [7:0]             rc[2] = '{8'h38, 8'h78};
	int                     pv[2] = '{10000, 5000};
	psmc_top #(.TICK_CYCLES(1), .BOOT_TICKS(5)) u_psmc_top (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .adc_sample(adc_sample), .afe_enable(afe_enable), .sample_done(sample_done),
		.mode(mode));
	psmc_conv_model u_psmc_conv_model (.clk_sys(clk_sys), .sys_rst(sys_rst), .afe_enable(afe_enable),
		.sample_done(sample_done), .adc_sample(adc_sample));
	initial forever #5 clk_sys = ~clk_sys;
	task automatic chk(string nm, logic [39:0] s, logic [39:0] x);
		n_tests++;
		if (s !== x) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, x, s);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(logic [7:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		chk("rvalid", 40'(reg_rvalid), 40'h1);
		v = reg_rdata;
	endtask : rd
	// Sample words are numbered in the order the converter stand-in hands them out.
	task automatic wait_done();
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (sample_done !== 1'b1 && n < 40000);
		chk("sample done", 40'(sample_done), 40'h1);
		e = {16'h3c00 + 16'(ncap), 24'h5a0000 + 24'(ncap)};
		ncap++;
	endtask : wait_done
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 100000) begin
			failures++;
			wrap_up();
		end
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(negedge clk_sys);
		chk("boot mode", 40'(mode), 40'(psmc_pkg::PSMC_BOOT));
		rd(8'h11);
		chk("request reset", 40'(v), 40'h0);
		repeat (10) @(negedge clk_sys);
		chk("idle mode", 40'(mode), 40'(psmc_pkg::PSMC_PDOWN));
		rd(8'h20);
		chk("unmapped", 40'(v), 40'h0);
		for (int i = 0; i < 7; i++) begin
			wr(8'h10, (i == 6) ? 8'h07 : 8'(i));
			rd(8'h10);
			chk("ctrl readback", 40'(v), 40'((i == 6) ? 7 : i));
			wr(8'h11, 8'h01);
			wait_done();
			chk("conv time", 40'(n >= cv[i] && n <= cv[i] + 6), 40'h1);
			chk("single end", 40'(mode), 40'(psmc_pkg::PSMC_PDOWN));
			rd(8'h11);
			chk("request clear", 40'(v), 40'h0);
			for (int j = 0; j < 5; j++) begin
				rd(8'h28 + 8'(j));
				chk("sample byte", 40'(v), 40'(e[8*j+:8]));
			end
		end
		for (int k = 0; k < 2; k++) begin
			wr(8'h10, rc[k]);
			wait_done();
			chk("cont mode", 40'(mode), 40'(psmc_pkg::PSMC_CONT));
			wait_done();
			chk("cont period", 40'(n >= pv[k] - 1 && n <= pv[k] + 1), 40'h1);
			rd(8'h28);
			chk("cont sample", 40'(v), 40'(e[7:0]));
		end
		wr(8'h11, 8'h01);
		rd(8'h11);
		chk("request dropped", 40'(v), 40'h0);
		chk("still cont", 40'(mode), 40'(psmc_pkg::PSMC_CONT));
		wr(8'h10, 8'h02);
		repeat (3) @(negedge clk_sys);
		chk("stop mode", 40'(mode), 40'(psmc_pkg::PSMC_PDOWN));
		chk("front end off", 40'(afe_enable), 40'h0);
		repeat (200) @(negedge clk_sys);
		rd(8'h28);
		chk("held sample", 40'(v), 40'(e[7:0]));
		rd(8'h10);
		chk("config kept", 40'(v), 40'h02);
		wrap_up();
	end
endmodule : tb
